// ### pkg/slave_two_pkg.sv
// Constants, register map and carrier types for the second I2C slave controller.
// Assumes a plain byte-wide register port clocked by sys_clk at 50 MHz.
// Functional notes
// - Debug enabled and address equals debug identifier: pulse debug interrupt, not slave traffic.
// - Debug disabled: regular slave; address bit 7 enables, bits 6-0 hold address.
// - Receive: shift SDA bits in, set receive-buffer flag per full byte.
// - New byte while receive flag set: NACK, or hold SCL low when stretching.
// - Receive stretch releases SCL only after software clears receive-buffer flag.
// - Transmit: on match load data byte to shifter, shift out, set transmit flag.
// - Shifter empty and transmit flag set: stretch if enabled, else resend old byte.
// - Master NACK after a byte ends data; release SDA for STOP or restart.
// - Noise filter enable suppresses short SDA/SCL pulses; disabled passes inputs.
// - Soft-reset bit 7 of config resets state machines and clears address register.
// - Five enable bits gate address, STOP, restart, transmit, receive flags to interrupt.
// - Config bit 0 reads one in slave transmit, zero in receive.
// - Status bit 7 marks first received byte after match; cleared when software reads the data register.
// - Address match sets sticky flag until software clears it.
// - STOP and repeated START set separate sticky flags cleared by software.
// - Data write clears transmit flag; data read clears receive flag.
// - Status bit 1 sets on START and clears on STOP.
// - Master NACK sets NACK bit, old byte resent; cleared by ACK or software.
// - SDA output delayed after SCL fall by hold-cycle field in status bits 3-0.
package slave_two_pkg;
  localparam logic [7:0] CONFIG_ADDR = 8'hDB;
  localparam logic [7:0] STATUS_ADDR = 8'hDC;
  localparam logic [7:0] SLAVE_ADDR_ADDR = 8'hDD;
  localparam logic [7:0] DATA_ADDR = 8'hDE;
  localparam logic [7:0] DEBUG_ID_ADDR = 8'hDF;
  localparam logic [7:0] DEBUG_CTRL_ADDR = 8'hE0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int CFG_SOFT_RESET_BIT = 7;
  localparam int CFG_DIR_BIT = 0;
  localparam int ST_FIRST_BIT = 7;
  localparam int ST_ADDRM_BIT = 6;
  localparam int ST_STOP_BIT = 5;
  localparam int ST_RSTART_BIT = 4;
  localparam int ST_TXB_BIT = 3;
  localparam int ST_RCB_BIT = 2;
  localparam int ST_START_BIT = 1;
  localparam int ST_NACK_BIT = 0;
  localparam int SYS_CLK_MHZ = 50;
  localparam int MIN_HOLD_NS = 300;
  localparam int MIN_HOLD_CYCLES = (MIN_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int HOLD_EXTRA_CYCLES = 3;
  localparam int LINE_DETECT_CYCLES = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic soft_reset;
    logic addrm_ie;
    logic stop_ie;
    logic rstart_ie;
    logic txb_ie;
    logic rcb_ie;
    logic stretch_en;
    logic filter_en;
  } config_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_WAIT} bus_state_t;
endpackage

// ### src/second_slave_controller.sv
// Second I2C slave controller: register port, line filter, conditions and byte engine.
// Assumes SCL/SDA are open-drain pins from an external master, asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module second_slave_controller
  import slave_two_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic slave_irq,
  output logic debug_interrupt
);
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_f_reg, sda_f_reg, scl_d_reg, sda_d_reg;
  config_t cfg_reg;
  logic [7:0] slave_address_register, debug_identifier_address, data_reg, shift_reg;
  logic debug_port_enable, dir_reg, first_reg, addrm_reg, stop_reg, rstart_reg;
  logic txb_reg, rcb_reg, start_reg, nack_reg;
  logic [3:0] sda_hold_cycles;
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [4:0] hold_cnt_reg;
  logic sda_low_reg, sda_low_next, stretch_reg, debug_xfer_reg, first_pend_reg;
  logic scl_rise, scl_fall, start_det, stop_det, wr_cfg, wr_st, wr_data, rd_data;
  logic rx_byte_done, addr_match_ev, tx_load_ev, mack_ev, ack_ev, srst;
  logic scl_p_reg, sda_p_reg, overrun_reg, rx_late_store;

  // Compares the request address with one register address; callers gate it with the write or read strobe.
  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  assign wr_cfg = req.wr && hit(req, CONFIG_ADDR);
  assign wr_st = req.wr && hit(req, STATUS_ADDR);
  assign wr_data = req.wr && hit(req, DATA_ADDR);
  assign rd_data = req.rd && hit(req, DATA_ADDR);
  assign srst = cfg_reg.soft_reset;

  // Two-flop synchronisers for the pin inputs.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  // Filter accepts a level only after it held for two samples; bypassed when disabled.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
      scl_p_reg <= scl_sync_reg[1];
      sda_p_reg <= sda_sync_reg[1];
      if (!cfg_reg.filter_en || scl_sync_reg[1] == scl_p_reg) begin
        scl_f_reg <= scl_sync_reg[1];
      end
      if (!cfg_reg.filter_en || sda_sync_reg[1] == sda_p_reg) begin
        sda_f_reg <= sda_sync_reg[1];
      end
    end
  end

  // Edge and condition detection on the cleaned lines.
  assign scl_rise = scl_f_reg && !scl_d_reg;
  assign scl_fall = !scl_f_reg && scl_d_reg;
  assign start_det = scl_f_reg && scl_d_reg && !sda_f_reg && sda_d_reg;
  assign stop_det = scl_f_reg && scl_d_reg && sda_f_reg && !sda_d_reg;
  assign rx_byte_done = scl_rise && state_reg == ST_RX && bit_cnt_reg == 4'h7;
  assign addr_match_ev = scl_rise && state_reg == ST_ADDR && bit_cnt_reg == 4'h7 && !debug_port_enable
    && slave_address_register[7] && {shift_reg[6:0], sda_f_reg} >> 1 == {1'b0, slave_address_register[6:0]};
  // Fresh transmit data is consumed at an address match for a read, or when the next byte is loaded.
  assign tx_load_ev = (addr_match_ev && sda_f_reg) || (state_reg == ST_ACK && dir_reg && bit_cnt_reg == 4'h9
    && (scl_fall || stretch_reg) && !nack_reg && !txb_reg);
  // A byte held back under stretching is stored in the cycle that software has freed the buffer.
  assign rx_late_store = state_reg == ST_WAIT && stretch_reg && overrun_reg && !rcb_reg;
  assign mack_ev = scl_rise && state_reg == ST_MACK;
  assign ack_ev = mack_ev && !sda_f_reg;

  // Configuration register; software clears the soft-reset bit itself.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= config_t'(CONFIG_RESET);
    end else if (wr_cfg) begin
      cfg_reg <= config_t'(req.wdata);
    end
  end

  // Address, debug id and hold-time fields; soft reset clears the address.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_address_register <= 8'h00;
      debug_identifier_address <= 8'h00;
      debug_port_enable <= 1'b0;
      sda_hold_cycles <= 4'h0;
    end else begin
      if (srst) begin
        slave_address_register <= 8'h00;
      end else if (req.wr && hit(req, SLAVE_ADDR_ADDR)) begin
        slave_address_register <= req.wdata;
      end
      if (req.wr && hit(req, DEBUG_ID_ADDR)) begin
        debug_identifier_address <= {1'b0, req.wdata[6:0]};
      end
      if (req.wr && hit(req, DEBUG_CTRL_ADDR)) begin
        debug_port_enable <= req.wdata[0];
      end
      if (wr_st) begin
        sda_hold_cycles <= req.wdata[3:0];
      end
    end
  end

  // Byte engine: address, ack, data phases with stretch and retransmit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      dir_reg <= 1'b0;
      sda_low_next <= 1'b0;
      stretch_reg <= 1'b0;
      debug_xfer_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (srst || stop_det) begin
      state_reg <= ST_IDLE;
      sda_low_next <= 1'b0;
      stretch_reg <= 1'b0;
      debug_xfer_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_low_next <= 1'b0;
      stretch_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_low_next <= 1'b0;
        end
        ST_ADDR: if (scl_rise) begin
          shift_reg <= {shift_reg[6:0], sda_f_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            if (debug_port_enable && shift_reg[6:0] == debug_identifier_address[6:0]) begin
              debug_xfer_reg <= 1'b1;
              state_reg <= ST_ACK;
              dir_reg <= sda_f_reg;
            end else if (addr_match_ev) begin
              state_reg <= ST_ACK;
              dir_reg <= sda_f_reg;
              if (sda_f_reg) begin
                shift_reg <= data_reg;
              end
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          // Count A marks the acknowledge of an address, whose byte was loaded at the match.
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            sda_low_next <= 1'b1;
            bit_cnt_reg <= 4'hA;
          end
          if ((scl_fall && bit_cnt_reg >= 4'h9) || stretch_reg) begin
            if (dir_reg && cfg_reg.stretch_en && txb_reg) begin
              stretch_reg <= 1'b1;
            end else begin
              stretch_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              if (dir_reg) begin
                shift_reg <= (bit_cnt_reg == 4'hA || nack_reg || txb_reg) ? shift_reg : data_reg;
                sda_low_next <= !((bit_cnt_reg == 4'hA || nack_reg || txb_reg) ? shift_reg[7] : data_reg[7]);
                state_reg <= ST_TX;
              end else begin
                sda_low_next <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
        end
        ST_RX: if (scl_rise) begin
          shift_reg <= {shift_reg[6:0], sda_f_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            overrun_reg <= rcb_reg;
            state_reg <= ST_WAIT;
          end
        end
        // SDA is pulled for the acknowledge one cycle before SCL is let go, never together with it.
        ST_WAIT: if (scl_fall || stretch_reg) begin
          if (stretch_reg && overrun_reg && !rcb_reg) begin
            overrun_reg <= 1'b0;
            sda_low_next <= 1'b1;
          end else if (overrun_reg && cfg_reg.stretch_en) begin
            stretch_reg <= 1'b1;
          end else begin
            stretch_reg <= 1'b0;
            sda_low_next <= !overrun_reg;
            bit_cnt_reg <= 4'h9;
            state_reg <= ST_ACK;
          end
        end
        ST_TX: if (scl_fall) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          shift_reg <= {shift_reg[6:0], shift_reg[7]};
          if (bit_cnt_reg == 4'h7) begin
            sda_low_next <= 1'b0;
            state_reg <= ST_MACK;
          end else begin
            sda_low_next <= !shift_reg[6];
          end
        end
        ST_MACK: if (mack_ev) begin
          if (sda_f_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            bit_cnt_reg <= 4'h9;
            state_reg <= ST_ACK;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Delays SDA changes after the SCL fall by the hold-cycle field.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= 5'h00;
      sda_low_reg <= 1'b0;
    end else if (scl_fall) begin
      // The fall is seen LINE_DETECT_CYCLES after the pin, so those cycles already count as hold.
      hold_cnt_reg <= {1'b0, sda_hold_cycles} + 5'(HOLD_EXTRA_CYCLES) - 5'(LINE_DETECT_CYCLES);
    end else if (hold_cnt_reg != 5'h00) begin
      hold_cnt_reg <= hold_cnt_reg - 5'h01;
    end else begin
      sda_low_reg <= sda_low_next;
    end
  end

  // Sticky flags; a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrm_reg <= 1'b0;
      stop_reg <= 1'b0;
      rstart_reg <= 1'b0;
      start_reg <= 1'b0;
      nack_reg <= 1'b0;
      txb_reg <= 1'b0;
      rcb_reg <= 1'b0;
      first_reg <= 1'b0;
      first_pend_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      addrm_reg <= addr_match_ev || (addrm_reg && !(wr_st && !req.wdata[ST_ADDRM_BIT]));
      stop_reg <= stop_det || (stop_reg && !(wr_st && !req.wdata[ST_STOP_BIT]));
      rstart_reg <= (start_det && start_reg) || (rstart_reg && !(wr_st && !req.wdata[ST_RSTART_BIT]));
      start_reg <= start_det || (start_reg && !stop_det);
      nack_reg <= (mack_ev && sda_f_reg) || (nack_reg && !ack_ev && !(wr_st && !req.wdata[ST_NACK_BIT]));
      txb_reg <= (tx_load_ev && !nack_reg) || (txb_reg && !wr_data);
      if (wr_data) begin
        data_reg <= req.wdata;
      end else if (rx_byte_done && !rcb_reg) begin
        data_reg <= {shift_reg[6:0], sda_f_reg};
      end else if (rx_late_store) begin
        data_reg <= shift_reg;
      end
      rcb_reg <= (rx_byte_done && !rcb_reg) || rx_late_store || (rcb_reg && !rd_data);
      first_pend_reg <= addr_match_ev || (first_pend_reg && !(rx_byte_done && !rcb_reg));
      first_reg <= (rx_byte_done && !rcb_reg && first_pend_reg) || (first_reg && !rd_data);
    end
  end

  // Read data, line drivers and interrupt outputs, all registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      slave_irq <= 1'b0;
      debug_interrupt <= 1'b0;
    end else begin
      rdata <= 8'h00;
      if (req.rd) begin
        if (hit(req, CONFIG_ADDR)) rdata <= {7'h00, dir_reg};
        else if (hit(req, STATUS_ADDR)) rdata <= {first_reg, addrm_reg, stop_reg, rstart_reg,
          txb_reg, rcb_reg, start_reg, nack_reg};
        else if (hit(req, SLAVE_ADDR_ADDR)) rdata <= slave_address_register;
        else if (hit(req, DATA_ADDR)) rdata <= data_reg;
        else if (hit(req, DEBUG_ID_ADDR)) rdata <= debug_identifier_address;
        else if (hit(req, DEBUG_CTRL_ADDR)) rdata <= {7'h00, debug_port_enable};
      end
      scl_oe <= stretch_reg && !scl_f_reg;
      // The line follows the engine as soon as the hold count has run out.
      sda_oe <= (hold_cnt_reg == 5'h00 && !scl_fall) ? sda_low_next : sda_low_reg;
      slave_irq <= (cfg_reg.addrm_ie && addrm_reg) || (cfg_reg.stop_ie && stop_reg)
        || (cfg_reg.rstart_ie && rstart_reg) || (cfg_reg.txb_ie && txb_reg)
        || (cfg_reg.rcb_ie && rcb_reg);
      debug_interrupt <= scl_rise && state_reg == ST_ADDR && bit_cnt_reg == 4'h7 && debug_port_enable
        && shift_reg[6:0] == debug_identifier_address[6:0];
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  addr_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) addr_match_ev |=> addrm_reg)
    else $error("address match flag not set");
  stop_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) stop_det |=> stop_reg && !start_reg)
    else $error("stop did not update flags");
  txb_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) wr_data && !tx_load_ev |=> !txb_reg)
    else $error("transmit flag not cleared by write");
  rcb_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) rd_data && !rx_byte_done |=> !rcb_reg)
    else $error("receive flag not cleared by read");
  srst_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) srst |=> slave_address_register == 8'h00)
    else $error("soft reset left address");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) (cfg_reg == '0) |=> !slave_irq)
    else $error("interrupt with all enables off");
  start_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) start_det && !stop_det |=> start_reg)
    else $error("start bit not set");
  stretch_rel_a: assert property (@(posedge sys_clk) disable iff (!rst_n) !stretch_reg |=> !scl_oe)
    else $error("scl held without stretch");
endmodule
`default_nettype wire

// ### sim/i2c_master_model.sv
// Behavioural I2C bus master driving open-drain SCL and SDA enables.
// Assumes the bench resolves both lines with pull-ups and feeds them back.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(parameter int LOW_NS = 120, parameter int HIGH_NS = 40) (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_oe,
  output logic sda_oe
);
  // Both lines stay released outside frames.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Moves every line change off the bench clock edges, so no change races a sample.
  task automatic align();
    if ($time % 10 == 0) #5;
  endtask
  // Releases SCL, waits out stretching for a bounded time, then holds the high phase.
  task automatic scl_rise();
    int n = 0;
    scl_oe = 1'b0;
    while (scl_line !== 1'b1 && n < 2000) begin
      #10;
      n++;
    end
    #(HIGH_NS);
  endtask
  // Data changes in the low phase and is sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    align();
    #20;
    sda_oe = ~b;
    #(LOW_NS - 20);
    scl_rise();
    s = sda_line;
    scl_oe = 1'b1;
  endtask
  task automatic start();
    align();
    #20;
    sda_oe = 1'b0;
    #(LOW_NS - 20);
    scl_rise();
    sda_oe = 1'b1;
    #(HIGH_NS);
    scl_oe = 1'b1;
  endtask
  task automatic stop();
    align();
    #20;
    sda_oe = 1'b1;
    #(LOW_NS - 20);
    scl_rise();
    sda_oe = 1'b0;
    #(HIGH_NS);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// ### sim/second_slave_controller_bench.sv
// Self-checking bench for the second I2C slave controller.
// Assumes pull-ups on SCL and SDA and a 160 ns bus clock from the master model.
`timescale 1ns/10ps
`default_nettype none
module second_slave_controller_bench;
  import slave_two_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, slave_irq, debug_interrupt, m_scl_oe, m_sda_oe, ack;
  logic [7:0] d;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int dbg_pulses = 0;
  wire logic scl_line = ~(scl_oe | m_scl_oe);
  wire logic sda_line = ~(sda_oe | m_sda_oe);

  second_slave_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .slave_irq(slave_irq), .debug_interrupt(debug_interrupt));
  i2c_master_model m (.scl_line(scl_line), .sda_line(sda_line), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  // Clock at 50 MHz.
  always #10 sys_clk = ~sys_clk;

  // Counts debug pulses and cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (debug_interrupt === 1'b1) dbg_pulses++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= w;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(negedge sys_clk);
    r = rdata;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    reg_rd(a, r);
    check(r, exp, what);
  endtask
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic t_reset();
    expect_reg(CONFIG_ADDR, CONFIG_RESET, "config reset");
    expect_reg(STATUS_ADDR, STATUS_RESET, "status reset");
    expect_reg(SLAVE_ADDR_ADDR, 8'h00, "address reset");
    expect_reg(8'hA0, 8'h00, "unmapped read");
    reg_wr(SLAVE_ADDR_ADDR, 8'hAA);
    expect_reg(SLAVE_ADDR_ADDR, 8'hAA, "address write");
    reg_wr(CONFIG_ADDR, 8'h80);
    reg_wr(CONFIG_ADDR, 8'h00);
    expect_reg(SLAVE_ADDR_ADDR, 8'h00, "soft reset");
  endtask
  // Master writes; the second byte is left unread so the third is refused.
  task automatic t_receive();
    reg_wr(SLAVE_ADDR_ADDR, 8'hAA);
    reg_wr(CONFIG_ADDR, 8'h40);
    m.start();
    m.wr_byte(8'h54, ack);
    check({7'h00, ack}, 8'h00, "address ack");
    m.wr_byte(8'hA5, ack);
    expect_reg(STATUS_ADDR, 8'hC6, "first byte status");
    check({7'h00, slave_irq}, 8'h01, "irq on match");
    expect_reg(DATA_ADDR, 8'hA5, "rx byte");
    expect_reg(STATUS_ADDR, 8'h42, "flags after read");
    m.wr_byte(8'h3C, ack);
    m.wr_byte(8'h77, ack);
    check({7'h00, ack}, 8'h01, "overrun nack");
    m.stop();
    settle();
    expect_reg(STATUS_ADDR, 8'h64, "after stop");
    reg_wr(CONFIG_ADDR, 8'h00);
    settle();
    check({7'h00, slave_irq}, 8'h00, "irq masked");
    reg_wr(CONFIG_ADDR, 8'h20);
    settle();
    check({7'h00, slave_irq}, 8'h01, "stop irq");
    expect_reg(DATA_ADDR, 8'h3C, "held byte");
    reg_wr(STATUS_ADDR, 8'h00);
    expect_reg(STATUS_ADDR, 8'h00, "flags cleared");
  endtask
  // With stretching on, an unread byte holds SCL until the data is read.
  task automatic t_stretch();
    int n = 0;
    reg_wr(CONFIG_ADDR, 8'h02);
    m.start();
    m.wr_byte(8'h54, ack);
    m.wr_byte(8'h11, ack);
    fork
      m.wr_byte(8'h3C, ack);
      begin
        while (scl_oe !== 1'b1 && n < 400) begin
          @(negedge sys_clk);
          n++;
        end
        repeat (40) @(negedge sys_clk);
        check({7'h00, scl_oe}, 8'h01, "stretch holds scl");
        expect_reg(DATA_ADDR, 8'h11, "byte under stretch");
      end
    join
    check({7'h00, ack}, 8'h00, "ack after release");
    expect_reg(DATA_ADDR, 8'h3C, "byte after stretch");
    m.stop();
    settle();
    reg_wr(STATUS_ADDR, 8'h00);
  endtask
  // Master reads, NACKs, restarts and gets the old byte again.
  task automatic t_transmit();
    reg_wr(CONFIG_ADDR, 8'h00);
    reg_wr(DATA_ADDR, 8'hC3);
    m.start();
    m.wr_byte(8'h55, ack);
    expect_reg(CONFIG_ADDR, 8'h01, "direction");
    expect_reg(STATUS_ADDR, 8'h4A, "tx status");
    reg_wr(DATA_ADDR, 8'h5A);
    expect_reg(STATUS_ADDR, 8'h42, "txb cleared");
    m.rd_byte(1'b0, d);
    check(d, 8'hC3, "tx byte");
    m.rd_byte(1'b1, d);
    check(d, 8'h5A, "second byte");
    repeat (12) @(negedge sys_clk);
    check({7'h00, sda_oe}, 8'h00, "sda released");
    m.start();
    m.wr_byte(8'h55, ack);
    m.rd_byte(1'b1, d);
    check(d, 8'h5A, "resend after nack");
    m.stop();
    settle();
    reg_rd(STATUS_ADDR, d);
    check(d & 8'h31, 8'h31, "stop restart nack");
    reg_wr(STATUS_ADDR, 8'h00);
  endtask
  // With stretching on, the first transmit byte waits until software writes it again.
  task automatic t_tx_stretch();
    int n = 0;
    reg_wr(CONFIG_ADDR, 8'h02);
    reg_wr(DATA_ADDR, 8'h96);
    m.start();
    m.wr_byte(8'h55, ack);
    fork
      m.rd_byte(1'b1, d);
      begin
        while (scl_oe !== 1'b1 && n < 400) begin
          @(negedge sys_clk);
          n++;
        end
        check({7'h00, scl_oe}, 8'h01, "tx stretch holds scl");
        reg_wr(DATA_ADDR, 8'h96);
      end
    join
    check(d, 8'h96, "byte after tx stretch");
    m.stop();
    settle();
    reg_wr(STATUS_ADDR, 8'h00);
  endtask
  // Debug address runs with the line filter switched on.
  task automatic t_debug();
    reg_wr(CONFIG_ADDR, 8'h01);
    reg_wr(DEBUG_ID_ADDR, 8'h33);
    reg_wr(DEBUG_CTRL_ADDR, 8'h01);
    m.start();
    m.wr_byte(8'h66, ack);
    m.stop();
    settle();
    check(dbg_pulses[7:0], 8'h01, "debug pulse");
    expect_reg(STATUS_ADDR, 8'h20, "no slave match");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_receive();
    t_stretch();
    t_transmit();
    t_tx_stretch();
    t_debug();
    summarize();
  end
endmodule
`default_nettype wire
